// file: hw/pal_consts.svh
// Constants of the port address latch and data repeater block.
// Assumes register byte address = index * 4 on a 32-bit APB bus.
// Summary of operation
// R1 - address latch strobe separates address phase from data phase on bus
// R2 - latched address output chosen pin by pin on ports A and B
// R3 - select bit 1 drives address on pin, 0 leaves normal port use
// R4 - port A select bit n routes latched address bit n to pin n
// R5 - port B pin n carries address bit n or n+8 per byte select
// R6 - both address select registers clear to zero on reset
// R7 - peripheral mode makes port A carry only the eight data bits
// R8 - repeater direction and enables follow read and write strobes in window
// R9 - window is the OR of the two peripheral select decodes
// R10 - window qualified by program store strobe high, data cycles only
// R11 - firmware sets repeater enable bit 7 before repeater works
// R12 - peripheral mode switches all eight port A pins together
// R13 - enabled repeater runs whenever core address falls inside window
// R14 - port A in peripheral mode serves no other function
// R15 - four test-port pins on port C stay dedicated
// R16 - two port C pins may show programming status and error
// R17 - drive type changeable at run time, default push-pull
// R18 - software reads each pin's final output enable
// R19 - output enable is OR of logic term, direction and repeater
// R20 - drive select bit 1 picks open-drain or fast slew
// R21 - address captured as latch strobe falls, held until next phase
// R22 - in-window read drives core bus, write drives port, else off
`ifndef PAL_CONSTS_SVH
`define PAL_CONSTS_SVH
`define PAL_IDX_ADDR_SEL_A 6'h02
`define PAL_IDX_ADDR_SEL_B 6'h03
`define PAL_IDX_DOUT_A 6'h04
`define PAL_IDX_DOUT_B 6'h05
`define PAL_IDX_DIR_A 6'h06
`define PAL_IDX_DIR_B 6'h07
`define PAL_IDX_DRV_A 6'h08
`define PAL_IDX_DRV_B 6'h09
`define PAL_IDX_OE_A 6'h0C
`define PAL_IDX_OE_B 6'h0D
`define PAL_IDX_HI_SEL_B 6'h20
`define PAL_IDX_MEM_MODE 6'h21
`define PAL_IDX_TEST_CFG 6'h22
`define PAL_RESET_BYTE 8'h00
`define PAL_REPEATER_EN_BIT 7
`define PAL_STATUS_EN_BIT 0
`define PAL_ERROR_EN_BIT 1
`define PAL_PERIPH_MODE_BIT 2
`define PAL_STATUS_PIN 3
`define PAL_ERROR_PIN 4
`define PAL_TEST_PORT_MASK 8'h63
`define PAL_ALL_ONES 8'hFF
`endif

// file: hw/pal_pkg.sv
// Types of the port address latch and data repeater block.
// Assumes the constants header is included by the design files.
package pal_pkg;
  typedef struct packed {
    logic [15:0] ad;
    logic ale;
    logic rdN;
    logic wrN;
    logic programStoreStrobe;
  } pal_core_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pal_port_t;

  typedef struct packed {
    logic [7:0] selA;
    logic [7:0] selB;
    logic [7:0] doutA;
    logic [7:0] doutB;
    logic [7:0] dirA;
    logic [7:0] dirB;
    logic [7:0] drvA;
    logic [7:0] drvB;
    logic [7:0] hiSelB;
    logic [7:0] memMode;
    logic [7:0] testCfg;
    logic [15:0] addrLatch;
    pal_port_t portA;
    pal_port_t portB;
    pal_port_t portC;
    logic [7:0] coreRdData;
    logic coreRdOe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pal_state_t;
endpackage : pal_pkg

// file: hw/pal_port_block.sv
// Port address latch, data repeater and port control registers.
// Assumes core bus and APB are synchronous to clk; pins are split
// into out and output-enable, the pad ring resolves the wire.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "pal_consts.svh"
module pal_port_block
  import pal_pkg::*;
(
  input wire logic clk, // 25 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire pal_core_t core, // multiplexed core bus
  input wire logic periphWindowSel0, // decode output 0
  input wire logic periphWindowSel1, // decode output 1
  input wire logic [7:0] laOutA, // logic array data, port A
  input wire logic [7:0] laOeA, // logic array enable term, port A
  input wire logic [7:0] laOutB, // logic array data, port B
  input wire logic [7:0] laOeB, // logic array enable term, port B
  input wire logic [7:0] portAIn, // port A pin levels
  input wire logic progStatus, // programming status from isp logic
  input wire logic progError, // programming error from isp logic
  output pal_port_t portA, // port A pin drive
  output pal_port_t portB, // port B pin drive
  output pal_port_t portC, // port C status and error pins
  output logic [7:0] driveSelA, // port A drive type
  output logic [7:0] driveSelB, // port B drive type
  output logic [7:0] coreRdData, // repeater data toward core
  output logic coreRdOe // repeater drives core bus
);

  pal_state_t st_r;
  pal_state_t st_nxt;

  function automatic logic isMapped(input logic [5:0] idx);
    unique case (idx)
      `PAL_IDX_ADDR_SEL_A, `PAL_IDX_ADDR_SEL_B,
      `PAL_IDX_DOUT_A, `PAL_IDX_DOUT_B,
      `PAL_IDX_DIR_A, `PAL_IDX_DIR_B,
      `PAL_IDX_DRV_A, `PAL_IDX_DRV_B,
      `PAL_IDX_OE_A, `PAL_IDX_OE_B,
      `PAL_IDX_HI_SEL_B, `PAL_IDX_MEM_MODE,
      `PAL_IDX_TEST_CFG: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction : isMapped

  function automatic logic [7:0] readReg(input pal_state_t s,
                                         input logic [5:0] idx);
    unique case (idx)
      `PAL_IDX_ADDR_SEL_A: readReg = s.selA;
      `PAL_IDX_ADDR_SEL_B: readReg = s.selB;
      `PAL_IDX_DOUT_A: readReg = s.doutA;
      `PAL_IDX_DOUT_B: readReg = s.doutB;
      `PAL_IDX_DIR_A: readReg = s.dirA;
      `PAL_IDX_DIR_B: readReg = s.dirB;
      `PAL_IDX_DRV_A: readReg = s.drvA;
      `PAL_IDX_DRV_B: readReg = s.drvB;
      `PAL_IDX_OE_A: readReg = s.portA.oe;
      `PAL_IDX_OE_B: readReg = s.portB.oe;
      `PAL_IDX_HI_SEL_B: readReg = s.hiSelB;
      `PAL_IDX_MEM_MODE: readReg = s.memMode;
      `PAL_IDX_TEST_CFG: readReg = s.testCfg;
      default: readReg = `PAL_RESET_BYTE;
    endcase
  endfunction : readReg

  logic [5:0] regIdx;
  logic aligned;
  logic setup;
  logic wrTake;
  logic periphMode;
  logic window;
  logic winRd;
  logic winWr;

  assign regIdx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup = psel && !penable;
  assign wrTake = psel && penable && st_r.pready && pwrite
                  && !st_r.pslverr;
  // port A taken as a whole into peripheral mode
  assign periphMode = st_r.testCfg[`PAL_PERIPH_MODE_BIT]; // R12 R14
  assign window = st_r.memMode[`PAL_REPEATER_EN_BIT] && periphMode // R11
                  && (periphWindowSel0 || periphWindowSel1) // R9 R13
                  && core.programStoreStrobe; // R10
  assign winRd = window && !core.rdN; // R8
  assign winWr = window && !core.wrN && core.rdN; // R8

  always_comb begin
    st_nxt = st_r;
    // apb: answer in the first access cycle
    st_nxt.pready = setup;
    st_nxt.pslverr = setup && !(aligned && isMapped(regIdx));
    if (setup) begin
      st_nxt.prdata = {24'h000000, readReg(st_r, regIdx)}; // R18
    end
    if (wrTake) begin
      unique case (regIdx)
        `PAL_IDX_ADDR_SEL_A: st_nxt.selA = pwdata[7:0]; // R2 R3
        `PAL_IDX_ADDR_SEL_B: st_nxt.selB = pwdata[7:0]; // R2 R3
        `PAL_IDX_DOUT_A: st_nxt.doutA = pwdata[7:0];
        `PAL_IDX_DOUT_B: st_nxt.doutB = pwdata[7:0];
        `PAL_IDX_DIR_A: st_nxt.dirA = pwdata[7:0];
        `PAL_IDX_DIR_B: st_nxt.dirB = pwdata[7:0];
        `PAL_IDX_DRV_A: st_nxt.drvA = pwdata[7:0]; // R17 R20
        `PAL_IDX_DRV_B: st_nxt.drvB = pwdata[7:0]; // R17 R20
        `PAL_IDX_HI_SEL_B: st_nxt.hiSelB = pwdata[7:0]; // R5
        `PAL_IDX_MEM_MODE: st_nxt.memMode = pwdata[7:0]; // R11
        `PAL_IDX_TEST_CFG: st_nxt.testCfg = pwdata[7:0];
        default: st_nxt.memMode = st_r.memMode;
      endcase
    end
    // address follows the bus while the strobe is high, holds after
    if (core.ale) begin
      st_nxt.addrLatch = core.ad; // R1 R21
    end
    // port A
    for (int i = 0; i < 8; i++) begin
      if (periphMode) begin
        // data bits only, no address on the port
        st_nxt.portA.out[i] = core.ad[i]; // R7 R22
        st_nxt.portA.oe[i] = laOeA[i] || st_r.dirA[i] || winWr; // R19
      end else if (st_r.selA[i]) begin
        st_nxt.portA.out[i] = st_r.addrLatch[i]; // R4
        st_nxt.portA.oe[i] = 1'b1; // R3
      end else begin
        st_nxt.portA.out[i] = laOeA[i] ? laOutA[i] : st_r.doutA[i];
        st_nxt.portA.oe[i] = laOeA[i] || st_r.dirA[i]; // R19
      end
    end
    // port B
    for (int i = 0; i < 8; i++) begin
      if (st_r.selB[i]) begin
        st_nxt.portB.out[i] = st_r.hiSelB[i] ? st_r.addrLatch[i + 8]
                                             : st_r.addrLatch[i]; // R5
        st_nxt.portB.oe[i] = 1'b1; // R3
      end else begin
        st_nxt.portB.out[i] = laOeB[i] ? laOutB[i] : st_r.doutB[i];
        st_nxt.portB.oe[i] = laOeB[i] || st_r.dirB[i]; // R19
      end
    end
    // port C: test-port pins never driven here
    st_nxt.portC.out = `PAL_RESET_BYTE; // R15
    st_nxt.portC.oe = `PAL_RESET_BYTE; // R15
    st_nxt.portC.out[`PAL_STATUS_PIN] = progStatus; // R16
    st_nxt.portC.oe[`PAL_STATUS_PIN] =
      st_r.testCfg[`PAL_STATUS_EN_BIT]; // R16
    st_nxt.portC.out[`PAL_ERROR_PIN] = progError; // R16
    st_nxt.portC.oe[`PAL_ERROR_PIN] =
      st_r.testCfg[`PAL_ERROR_EN_BIT]; // R16
    // repeater toward the core
    st_nxt.coreRdOe = winRd; // R22
    st_nxt.coreRdData = winRd ? portAIn : st_r.coreRdData; // R22
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0; // R6 R17
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign portA = st_r.portA;
  assign portB = st_r.portB;
  assign portC = st_r.portC;
  assign driveSelA = st_r.drvA;
  assign driveSelB = st_r.drvB;
  assign coreRdData = st_r.coreRdData;
  assign coreRdOe = st_r.coreRdOe;

  a_addr_capture: assert property ( // R21
    @(posedge clk) disable iff (!reset_n)
    $fell(core.ale) |-> ##1 st_r.addrLatch == $past(core.ad, 2))
    else $error("address not held from strobe fall");

  a_addr_hold: assert property ( // R1
    @(posedge clk) disable iff (!reset_n)
    (!core.ale && $past(!core.ale)) |=> $stable(st_r.addrLatch))
    else $error("address changed outside address phase");

  a_porta_addr: assert property ( // R4
    @(posedge clk) disable iff (!reset_n)
    (!periphMode && st_r.selA == `PAL_ALL_ONES)
    |=> portA.out == $past(st_r.addrLatch[7:0])
        && portA.oe == `PAL_ALL_ONES)
    else $error("port A address pins wrong");

  a_portb_high: assert property ( // R5
    @(posedge clk) disable iff (!reset_n)
    (st_r.selB[1] && st_r.hiSelB[1])
    |=> portB.out[1] == $past(st_r.addrLatch[9]))
    else $error("port B high address byte wrong");

  a_repeater_write: assert property ( // R8
    @(posedge clk) disable iff (!reset_n)
    (winWr && periphWindowSel0)
    |=> portA.oe == `PAL_ALL_ONES && portA.out == $past(core.ad[7:0]))
    else $error("repeater write not driven to port");

  a_window_or: assert property ( // R9
    @(posedge clk) disable iff (!reset_n)
    (st_r.memMode[7] && periphMode && core.programStoreStrobe
     && periphWindowSel1 && !periphWindowSel0 && !core.rdN)
    |=> coreRdOe)
    else $error("second select does not open window");

  a_repeater_read: assert property ( // R22
    @(posedge clk) disable iff (!reset_n)
    winRd |=> coreRdOe && coreRdData == $past(portAIn))
    else $error("repeater read data wrong");

  a_code_fetch: assert property ( // R10
    @(posedge clk) disable iff (!reset_n)
    !core.programStoreStrobe |=> !coreRdOe)
    else $error("repeater active in code cycle");

  a_repeater_gate: assert property ( // R11
    @(posedge clk) disable iff (!reset_n)
    !st_r.memMode[`PAL_REPEATER_EN_BIT] |=> !coreRdOe)
    else $error("repeater active while disabled");

  a_test_pins: assert property ( // R15
    @(posedge clk) disable iff (!reset_n)
    (portC.oe & `PAL_TEST_PORT_MASK) == `PAL_RESET_BYTE)
    else $error("test-port pin driven");

  a_oe_readback: assert property ( // R18
    @(posedge clk) disable iff (!reset_n)
    (setup && paddr == {`PAL_IDX_OE_A, 2'b00})
    |=> pready && prdata[7:0] == $past(portA.oe) && prdata[31:8] == 0)
    else $error("enable read-back wrong");

  a_drive_write: assert property ( // R17
    @(posedge clk) disable iff (!reset_n)
    (wrTake && regIdx == `PAL_IDX_DRV_B && aligned)
    |=> driveSelB == $past(pwdata[7:0]))
    else $error("drive select not written");

  // register file: reset state, writes and holds
  a_reset_clear: assert property ( // R6
    @(posedge clk) disable iff (!reset_n)
    !$past(reset_n) |-> st_r.selA == `PAL_RESET_BYTE
                        && st_r.selB == `PAL_RESET_BYTE)
    else $error("address selects not cleared by reset");

  a_sel_write: assert property ( // R3
    @(posedge clk) disable iff (!reset_n)
    (wrTake && regIdx == `PAL_IDX_ADDR_SEL_A && aligned)
    |=> st_r.selA == $past(pwdata[7:0]))
    else $error("address select A not written");

  a_sel_hold: assert property ( // R2
    @(posedge clk) disable iff (!reset_n)
    !wrTake |=> $stable(st_r.selA) && $stable(st_r.selB))
    else $error("address select changed without write");

  a_drive_a: assert property ( // R20
    @(posedge clk) disable iff (!reset_n)
    (wrTake && regIdx == `PAL_IDX_DRV_A && aligned)
    |=> driveSelA == $past(pwdata[7:0]))
    else $error("drive select A not written");

  // apb answers and refusals
  a_ready_answer: assert property ( // R18
    @(posedge clk) disable iff (!reset_n)
    setup |=> pready ##1 !pready)
    else $error("apb answer not a one-cycle pulse");

  a_unmapped_err: assert property ( // R18
    @(posedge clk) disable iff (!reset_n)
    (setup && !isMapped(regIdx))
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  a_read_upper: assert property ( // R18
    @(posedge clk) disable iff (!reset_n)
    prdata[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");

  // pin routing and repeater
  a_addr_follow: assert property ( // R1
    @(posedge clk) disable iff (!reset_n)
    core.ale |=> st_r.addrLatch == $past(core.ad))
    else $error("address not taken in address phase");

  a_portb_low: assert property ( // R5
    @(posedge clk) disable iff (!reset_n)
    (st_r.selB[2] && !st_r.hiSelB[2])
    |=> portB.out[2] == $past(st_r.addrLatch[2]) && portB.oe[2])
    else $error("port B low address bit wrong");

  a_portb_default: assert property ( // R19
    @(posedge clk) disable iff (!reset_n)
    !st_r.selB[5]
    |=> portB.oe[5] == $past(laOeB[5] || st_r.dirB[5]))
    else $error("port B enable not logic term or direction");

  a_periph_data: assert property ( // R12
    @(posedge clk) disable iff (!reset_n)
    periphMode |=> portA.out == $past(core.ad[7:0]))
    else $error("port A not carrying data in peripheral mode");

  a_read_release: assert property ( // R22
    @(posedge clk) disable iff (!reset_n)
    (periphMode && !core.rdN)
    |=> portA.oe == $past(laOeA | st_r.dirA))
    else $error("port A driven during repeater read");

  a_window_closed: assert property ( // R13
    @(posedge clk) disable iff (!reset_n)
    !(periphWindowSel0 || periphWindowSel1) |=> !coreRdOe)
    else $error("repeater active outside window");

  a_mode_gate: assert property ( // R7
    @(posedge clk) disable iff (!reset_n)
    !periphMode |=> !coreRdOe)
    else $error("repeater active outside peripheral mode");

  a_status_pin: assert property ( // R16
    @(posedge clk) disable iff (!reset_n)
    st_r.testCfg[`PAL_STATUS_EN_BIT]
    |=> portC.oe[`PAL_STATUS_PIN]
        && portC.out[`PAL_STATUS_PIN] == $past(progStatus))
    else $error("status pin not driven");

  a_error_pin: assert property ( // R16
    @(posedge clk) disable iff (!reset_n)
    st_r.testCfg[`PAL_ERROR_EN_BIT]
    |=> portC.oe[`PAL_ERROR_PIN]
        && portC.out[`PAL_ERROR_PIN] == $past(progError))
    else $error("error pin not driven");

endmodule : pal_port_block

// file: tb/pal_periph_model.sv
// Behavioural parallel peripheral hanging on port A.
// Assumes the core strobes are shared with the block and port A is split
// into out and output enable.
`timescale 1ns/1ps
module pal_periph_model
  import pal_pkg::*;
(
  input wire logic clk, // bus clock
  input wire pal_port_t portA, // port A drive from the block
  input wire pal_core_t core, // core strobes
  output logic [7:0] portAIn // level seen on port A pins
);
  logic [7:0] stored_r = 8'h00;
  logic [7:0] lastLevel_r = 8'h00;
  logic driveOn;
  // answers a read only while the block has let go of the pins
  assign driveOn = (core.rdN === 1'b0) && (portA.oe === 8'h00);
  // released pins show a level that flips every cycle
  assign portAIn = driveOn ? stored_r : ~lastLevel_r;
  always @(posedge clk) begin
    lastLevel_r <= portAIn;
    if (portA.oe === 8'hFF && core.wrN === 1'b0) begin
      stored_r <= portA.out;
    end
  end
endmodule : pal_periph_model

// file: tb/tb.sv
// Self-checking bench of the port address latch and data repeater.
// Assumes zero or more APB wait states and one-cycle pin latency.
`timescale 1ns/1ps
module tb;
  import pal_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, coreRdOe;
  pal_core_t core = '{16'h0000, 1'b0, 1'b1, 1'b1, 1'b0};
  logic sel0 = 1'b0, sel1 = 1'b0, progStatus = 1'b0, progError = 1'b0;
  logic [7:0] laOutB = 8'h00, laOeB = 8'h00;
  logic [7:0] portAIn, driveSelA, driveSelB, coreRdData;
  pal_port_t portA, portB, portC;
  int fail_count = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  pal_port_block u_pal_port_block (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core(core), .periphWindowSel0(sel0), .periphWindowSel1(sel1),
    .laOutA(8'h00), .laOeA(8'h00), .laOutB(laOutB), .laOeB(laOeB),
    .portAIn(portAIn), .progStatus(progStatus), .progError(progError),
    .portA(portA), .portB(portB), .portC(portC), .driveSelA(driveSelA),
    .driveSelB(driveSelB), .coreRdData(coreRdData), .coreRdOe(coreRdOe));
  pal_periph_model u_pal_periph_model (.clk(clk), .portA(portA),
    .core(core), .portAIn(portAIn));
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string m);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1, "apb ready wait");
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
    chk(e, 1'b0, "write error flag");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, {24'h0, x}, "read data");
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic t_reset;
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h84, 8'h00);
    rd(8'h20, 8'h00);
    chk(portA.oe, 8'h00, "port A idle enable");
    $display("test reset done");
  endtask : t_reset
  task automatic t_latch;
    wr(8'h08, 8'hFF);
    wr(8'h0C, 8'h0F);
    wr(8'h80, 8'h03);
    @(posedge clk);
    core.ale <= 1'b1;
    core.ad <= 16'h1234;
    @(posedge clk);
    core.ale <= 1'b0;
    core.ad <= 16'h00C3;
    cyc(3);
    chk(portA.out, 8'h34, "port A address");
    chk(portA.oe, 8'hFF, "port A address enable");
    chk(portB.out, 8'h06, "port B byte select");
    chk(portB.oe, 8'h0F, "port B per pin");
    rd(8'h30, 8'hFF);
    $display("test latch done");
  endtask : t_latch
  task automatic t_repeat;
    wr(8'h84, 8'h80);
    wr(8'h88, 8'h04);
    core.programStoreStrobe <= 1'b1;
    sel0 <= 1'b1;
    core.wrN <= 1'b0;
    core.ad <= 16'h00A5;
    cyc(2);
    chk(portA.out, 8'hA5, "repeater write data");
    chk(portA.oe, 8'hFF, "repeater write enable");
    core.wrN <= 1'b1;
    sel0 <= 1'b0;
    sel1 <= 1'b1;
    core.rdN <= 1'b0;
    cyc(3);
    chk(portA.oe, 8'h00, "repeater read enable");
    chk(coreRdOe, 1'b1, "repeater read drive");
    chk(coreRdData, 8'hA5, "repeater read data");
    core.programStoreStrobe <= 1'b0;
    cyc(2);
    chk(coreRdOe, 1'b0, "code cycle");
    core.programStoreStrobe <= 1'b1;
    sel1 <= 1'b0;
    cyc(2);
    chk(coreRdOe, 1'b0, "outside window");
    wr(8'h84, 8'h00);
    sel1 <= 1'b1;
    cyc(2);
    chk(coreRdOe, 1'b0, "repeater disabled");
    core.rdN <= 1'b1;
    sel1 <= 1'b0;
    $display("test repeater done");
  endtask : t_repeat
  task automatic t_misc;
    logic [31:0] r;
    logic e;
    wr(8'h1C, 8'hF0);
    rd(8'h34, 8'hFF);
    wr(8'h1C, 8'h00);
    laOeB <= 8'h30;
    laOutB <= 8'h20;
    cyc(2);
    chk(portB.oe, 8'h3F, "logic term enable");
    chk(portB.out, 8'h26, "logic term data");
    wr(8'h20, 8'h5A);
    wr(8'h24, 8'hA5);
    cyc(2);
    chk(driveSelA, 8'h5A, "drive select");
    chk(driveSelB, 8'hA5, "drive select B");
    wr(8'h88, 8'h07);
    progStatus <= 1'b1;
    progError <= 1'b1;
    cyc(2);
    chk(portC.out[4:3], 2'b11, "status pins");
    chk(portC.oe, 8'h18, "status enables");
    chk(portC.oe & 8'h63, 8'h00, "test pins");
    apb(1'b0, 8'hFC, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped read data");
    $display("test misc done");
  endtask : t_misc
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_latch;
    t_repeat;
    t_misc;
    give_verdict;
  end
endmodule : tb
